// >>> rtl/tmr_pkg.sv
// Package: register map, field layout and timing of the 16-bit timer
// Operation
// [R1] Count kept as two writable bytes, counts up and wraps to zero.
// [R2] Wrap from all ones sets the sticky overflow flag, bit zero.
// [R3] Overflow interrupt requested only while its enable bit is set.
// [R4] Control bit 1 picks internal instruction clock or external pin.
// [R5] Timer mode advances once per instruction cycle, quarter oscillator rate.
// [R6] Counter mode advances on rising external edges only.
// [R7] Control bit 0 runs the count; cleared, the count holds.
// [R8] Capture/compare reset input clears the whole count.
// [R9] Control bit 3 enables oscillator; both oscillator pins become inputs.
// [R10] Bits 5:4 choose prescale 1:1, 1:2, 1:4 or 1:8.
// [R11] Control bits 7:6 read zero and ignore writes.
// [R12] Bit 2 set bypasses external input sync; clear synchronises it.
// [R13] Sync bit ignored when internal clock is selected.
// [R14] Reset clears all control bits: stopped, internal, 1:1, osc off.
// [R15] Software rereads high byte after low and repeats on change.
package tmr_pkg;
   localparam logic [7:0] ADDR_COUNT_LO = 8'h0E;
   localparam logic [7:0] ADDR_COUNT_HI = 8'h0F;
   localparam logic [7:0] ADDR_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0D;
   localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8C;
   localparam int BIT_RUN = 0;
   localparam int BIT_SRC = 1;
   localparam int BIT_SYNC = 2;
   localparam int BIT_OSC = 3;
   localparam int BIT_PS_LO = 4;
   localparam int BIT_PS_HI = 5;
   localparam int BIT_OVF = 0;
   localparam logic [7:0] CONTROL_MASK = 8'h3F;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

   typedef struct packed {
      logic [1:0] prescale;
      logic osc_enable;
      logic sync_bypass;
      logic clock_source_select;
      logic count_run;
   } control_t;
endpackage

// >>> rtl/timer16.sv
// Sixteen-bit timer/counter with prescaler, register port and interrupt
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module timer16 #(
   parameter int AW = 8
) (
   clk,
   rst,
   addr,
   wdata,
   wr,
   rd,
   rdata,
   ext_clock_pin,
   osc_in_pin,
   ccp_reset,
   osc_out_pin_oe,
   osc_in_pin_oe,
   osc_run,
   irq
);
   input wire logic clk;
   input wire logic rst;
   input wire logic [AW-1:0] addr;
   input wire logic [7:0] wdata;
   input wire logic wr;
   input wire logic rd;
   output logic [7:0] rdata;
   input wire logic ext_clock_pin;
   input wire logic osc_in_pin;
   input wire logic ccp_reset;
   output logic osc_out_pin_oe;
   output logic osc_in_pin_oe;
   output logic osc_run;
   output logic irq;

   initial begin
      if (AW < 8) $error("AW must be at least 8");
   end

   tmr_pkg::control_t ctl_q;
   logic [15:0] count_q;
   logic [2:0] pre_q;
   logic [1:0] qdiv_q;
   logic ovf_q;
   logic ovf_en_q;
   logic ext_s1_q, ext_s2_q, ext_prev_q, ext_raw_prev_q;
   logic src_pin, tick, pre_tick, ext_rise, wrap;

   function automatic logic sel(input logic [AW-1:0] a,
                                input logic [7:0] r);
      sel = (a == AW'(r));
   endfunction

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_q <= tmr_pkg::control_t'(tmr_pkg::CONTROL_RESET[5:0]); // [R14]
      end else if (wr && sel(addr, tmr_pkg::ADDR_CONTROL)) begin
         ctl_q <= tmr_pkg::control_t'(wdata[5:0]); // [R11]
      end
   end

   // ---------------------------------------------------------------
   // Clock source and prescaler
   // ---------------------------------------------------------------
   // Crystal drives osc input; else external clock pin
   assign src_pin = ctl_q.osc_enable ? osc_in_pin : ext_clock_pin;

   always_ff @(posedge clk) begin
      if (rst) begin
         qdiv_q <= 2'h0;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_prev_q <= 1'b0;
         ext_raw_prev_q <= 1'b0;
      end else begin
         qdiv_q <= qdiv_q + 2'h1;
         ext_s1_q <= src_pin;
         ext_s2_q <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
         ext_raw_prev_q <= src_pin;
      end
   end

   always_comb begin
      if (ctl_q.sync_bypass) begin
         ext_rise = src_pin && !ext_raw_prev_q; // [R12]
      end else begin
         ext_rise = ext_s2_q && !ext_prev_q; // [R12] [R6]
      end
      if (ctl_q.clock_source_select) begin // [R4]
         pre_tick = ext_rise;
      end else begin
         pre_tick = (qdiv_q == tmr_pkg::INSTR_DIV_LAST); // [R5] [R13]
      end
      case (ctl_q.prescale) // [R10]
         2'h0: tick = pre_tick;
         2'h1: tick = pre_tick && pre_q[0];
         2'h2: tick = pre_tick && (pre_q[1:0] == 2'h3);
         default: tick = pre_tick && (pre_q == 3'h7);
      endcase
      tick = tick && ctl_q.count_run; // [R7]
   end

   always_ff @(posedge clk) begin
      if (rst || ccp_reset) begin
         pre_q <= 3'h0;
      end else if (wr && (sel(addr, tmr_pkg::ADDR_COUNT_LO) ||
                          sel(addr, tmr_pkg::ADDR_COUNT_HI))) begin
         pre_q <= 3'h0;
      end else if (pre_tick && ctl_q.count_run) begin
         pre_q <= pre_q + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // Count register
   // ---------------------------------------------------------------
   assign wrap = tick && (count_q == 16'hFFFF);

   always_ff @(posedge clk) begin
      if (rst || ccp_reset) begin
         count_q <= 16'h0000; // [R8]
      end else if (wr && sel(addr, tmr_pkg::ADDR_COUNT_LO)) begin
         count_q[7:0] <= wdata; // [R1]
      end else if (wr && sel(addr, tmr_pkg::ADDR_COUNT_HI)) begin
         count_q[15:8] <= wdata; // [R1]
      end else if (tick) begin
         count_q <= count_q + 16'h0001; // [R1]
      end
   end

   // ---------------------------------------------------------------
   // Interrupt flag and enable
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ovf_q <= 1'b0;
      end else if (wrap) begin
         ovf_q <= 1'b1; // [R2]
      end else if (wr && sel(addr, tmr_pkg::ADDR_IRQ_CLEAR) &&
                   wdata[tmr_pkg::BIT_OVF]) begin
         ovf_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ovf_en_q <= 1'b0;
      end else if (wr && sel(addr, tmr_pkg::ADDR_IRQ_ENABLES)) begin
         ovf_en_q <= wdata[tmr_pkg::BIT_OVF];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= (ovf_q || wrap) && ovf_en_q; // [R3]
      end
   end

   // ---------------------------------------------------------------
   // Oscillator pins
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_run <= 1'b0;
         osc_in_pin_oe <= 1'b0;
         osc_out_pin_oe <= 1'b0;
      end else begin
         osc_run <= ctl_q.osc_enable; // [R9]
         osc_in_pin_oe <= 1'b0; // [R9]
         osc_out_pin_oe <= 1'b0; // [R9]
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         if (sel(addr, tmr_pkg::ADDR_COUNT_LO)) rdata <= count_q[7:0];
         else if (sel(addr, tmr_pkg::ADDR_COUNT_HI)) begin
            rdata <= count_q[15:8];
         end else if (sel(addr, tmr_pkg::ADDR_CONTROL)) begin
            rdata <= {2'b00, ctl_q}; // [R11]
         end else if (sel(addr, tmr_pkg::ADDR_IRQ_FLAGS)) begin
            rdata <= {7'h00, ovf_q};
         end else if (sel(addr, tmr_pkg::ADDR_IRQ_ENABLES)) begin
            rdata <= {7'h00, ovf_en_q};
         end else rdata <= 8'h00;
      end else begin
         rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence wrap_s;
      tick && count_q == 16'hFFFF;
   endsequence

   wrap_flag_a: assert property (@(posedge clk) disable iff (rst) // [R2]
      wrap_s ##0 (!wr && !ccp_reset) |=> ovf_q && count_q == 16'h0000)
      else $error("wrap did not set overflow flag");
   irq_mask_a: assert property (@(posedge clk) disable iff (rst) // [R3]
      !$past(ovf_en_q) |-> !irq)
      else $error("interrupt while masked");
   hold_stop_a: assert property (@(posedge clk) disable iff (rst) // [R7]
      !ctl_q.count_run && !wr && !ccp_reset |=> $stable(count_q))
      else $error("count moved while stopped");
   ccp_clear_a: assert property (@(posedge clk) disable iff (rst) // [R8]
      ccp_reset |=> count_q == 16'h0000)
      else $error("capture reset did not clear count");
   ctl_upper_a: assert property (@(posedge clk) disable iff (rst) // [R11]
      $past(rd) && $past(sel(addr, tmr_pkg::ADDR_CONTROL))
      |-> rdata[7:6] == 2'b00)
      else $error("control upper bits not zero");
   timer_rate_a: assert property (@(posedge clk) disable iff (rst) // [R5]
      !ctl_q.clock_source_select && ctl_q.prescale == 2'h0 && tick
      |=> !tick [*3])
      else $error("timer ticked faster than quarter rate");
   osc_pins_a: assert property (@(posedge clk) disable iff (rst) // [R9]
      ctl_q.osc_enable |=> osc_run && !osc_in_pin_oe && !osc_out_pin_oe)
      else $error("oscillator pins not inputs");
   reset_ctl_a: assert property (@(posedge clk) // [R14]
      rst |=> ctl_q == tmr_pkg::control_t'(tmr_pkg::CONTROL_RESET[5:0]))
      else $error("control not cleared by reset");
   step_one_a: assert property (@(posedge clk) disable iff (rst) // [R1]
      tick && !wr && !ccp_reset |=> count_q == $past(count_q) + 16'h0001)
      else $error("count did not step by one");

   // ---------------------------------------------------------------
   // Flag, interrupt, source, prescale, run, oscillator, control, reset and read checks
   // ---------------------------------------------------------------
   // Software clear of the overflow flag
   sequence flag_clear_s;
      wr && sel(addr, tmr_pkg::ADDR_IRQ_CLEAR) && wdata[tmr_pkg::BIT_OVF];
   endsequence

   // No wrap in the same cycle, so the clear may win
   sequence no_wrap_s;
      !wrap;
   endsequence

   flag_clr_a: assert property (@(posedge clk) disable iff (rst) // [R2]
      flag_clear_s ##0 no_wrap_s |=> !ovf_q)
      else $error("overflow flag not cleared");

   flag_sticky_a: assert property (@(posedge clk) disable iff (rst) // [R2]
      ovf_q && !(wr && sel(addr, tmr_pkg::ADDR_IRQ_CLEAR)) |=> ovf_q)
      else $error("overflow flag dropped by itself");

   irq_level_a: assert property (@(posedge clk) disable iff (rst) // [R3]
      ovf_q && ovf_en_q |=> irq)
      else $error("enabled flag gave no interrupt");

   irq_cause_a: assert property (@(posedge clk) disable iff (rst) // [R3]
      irq |-> $past(ovf_q || wrap))
      else $error("interrupt without overflow");

   src_internal_a: assert property (@(posedge clk) disable iff (rst) // [R4] [R13]
      !ctl_q.clock_source_select && tick |-> qdiv_q == tmr_pkg::INSTR_DIV_LAST)
      else $error("internal tick off the instruction cycle");

   src_external_a: assert property (@(posedge clk) disable iff (rst) // [R6]
      ctl_q.clock_source_select && tick |-> ext_rise)
      else $error("external tick without rising edge");

   bypass_fall_a: assert property (@(posedge clk) disable iff (rst) // [R12]
      ctl_q.sync_bypass && !src_pin |-> !ext_rise)
      else $error("edge seen on low input");

   sync_edge_a: assert property (@(posedge clk) disable iff (rst) // [R12]
      !ctl_q.sync_bypass && ext_rise |-> $past(src_pin, 2) &&
      !$past(src_pin, 3))
      else $error("synchronised edge not a rising edge");

   pre_half_a: assert property (@(posedge clk) disable iff (rst) // [R10]
      ctl_q.prescale == 2'h1 && tick |-> pre_q[0])
      else $error("prescale 1:2 ticked early");

   pre_eighth_a: assert property (@(posedge clk) disable iff (rst) // [R10]
      ctl_q.prescale == 2'h3 && tick |-> pre_q == 3'h7)
      else $error("prescale 1:8 ticked early");

   run_gate_a: assert property (@(posedge clk) disable iff (rst) // [R7]
      tick |-> ctl_q.count_run)
      else $error("tick while stopped");

   osc_off_a: assert property (@(posedge clk) disable iff (rst) // [R9]
      !ctl_q.osc_enable |=> !osc_run)
      else $error("oscillator running while disabled");

   ctl_write_a: assert property (@(posedge clk) disable iff (rst) // [R11]
      wr && sel(addr, tmr_pkg::ADDR_CONTROL) |=>
      ctl_q == tmr_pkg::control_t'($past(wdata[5:0])))
      else $error("control write not taken");

   ccp_pre_a: assert property (@(posedge clk) disable iff (rst) // [R8]
      ccp_reset |=> pre_q == 3'h0)
      else $error("capture reset did not clear prescaler");

   reset_out_a: assert property (@(posedge clk) // [R14]
      rst |=> !irq && !osc_run && !ovf_q && !ovf_en_q)
      else $error("outputs not cleared by reset");

   rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
      !rd |=> rdata == 8'h00)
      else $error("read data not zero without read");
endmodule // timer16

// >>> verification/ext_clock_src.sv
// External clock and crystal source that drives the timer's input pins
`timescale 1ns/1ps
module ext_clock_src (
   ext_clock_pin,
   osc_in_pin
);
   output logic ext_clock_pin;
   output logic osc_in_pin;
   initial begin
      ext_clock_pin = 1'b0;
      osc_in_pin = 1'b0;
   end
   // Burst of n pulses, idle low outside; sel picks the crystal pin
   task automatic pulses(input int n, input bit sel);
      #3;
      for (int i = 0; i < n; i++) begin
         #40;
         if (sel) osc_in_pin = 1'b1;
         else ext_clock_pin = 1'b1;
         #40;
         osc_in_pin = 1'b0;
         ext_clock_pin = 1'b0;
      end
   endtask
endmodule // ext_clock_src

// >>> verification/test_timer16.sv
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
module test_timer16;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ccp_reset = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, w;
   logic oe_o, oe_i, osc_run, irq, ext_pin, osc_pin;
   int err_total = 0, checked = 0;
   row_t rows[8] = '{'{8'h10, 8'hFF, 8'h3F}, '{8'h10, 8'hC0, 8'h00},
      '{8'h8C, 8'h01, 8'h01}, '{8'h20, 8'hAA, 8'h00},
      '{8'h0E, 8'h5A, 8'h5A}, '{8'h0F, 8'hA5, 8'hA5},
      '{8'h0C, 8'h01, 8'h00}, '{8'h8C, 8'h00, 8'h00}};
   logic [7:0] ctl[5] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h05};
   int exps[5] = '{16, 8, 4, 2, 16};
   always #4 clk = ~clk;
   timer16 dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .ext_clock_pin(ext_pin), .osc_in_pin(osc_pin),
      .ccp_reset(ccp_reset), .osc_out_pin_oe(oe_o), .osc_in_pin_oe(oe_i),
      .osc_run(osc_run), .irq(irq));
   ext_clock_src src (.ext_clock_pin(ext_pin), .osc_in_pin(osc_pin));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic ext_run(input logic [7:0] c, input int n, input bit s);
      wr_reg(8'h0E, 8'h00);
      wr_reg(8'h0F, 8'h00);
      wr_reg(8'h10, c);
      src.pulses(n, s);
      repeat (8) @(posedge clk);
      chk("osc_run", {7'h00, osc_run}, {7'h00, c[3]});
      chk("pin_oe", {6'h00, oe_o, oe_i}, 8'h00);
      wr_reg(8'h10, 8'h00);
      rd_reg(8'h0E, v);
      chk("ext_count", v, n[7:0]);
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      #300000;
      err_total++;
      wrap_up;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_reg(8'h10, v);
      chk("ctl_reset", v, 8'h00);
      chk("irq_reset", {irq, osc_run}, 8'h00);
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_reg(rows[i].a, v);
         chk("reg", v, rows[i].e);
      end
      foreach (ctl[i]) begin
         wr_reg(8'h0E, 8'h00);
         wr_reg(8'h0F, 8'h00);
         wr_reg(8'h10, ctl[i]);
         repeat (63) @(posedge clk);
         wr_reg(8'h10, 8'h00);
         rd_reg(8'h0E, v);
         chk("rate", v >= exps[i] - 1 && v <= exps[i] + 1, 8'h01);
      end
      ext_run(8'h03, 5, 1'b0);
      ext_run(8'h0F, 3, 1'b1);
      wr_reg(8'h8C, 8'h01);
      wr_reg(8'h0E, 8'hFF);
      wr_reg(8'h0F, 8'hFF);
      wr_reg(8'h10, 8'h01);
      repeat (12) @(posedge clk);
      wr_reg(8'h10, 8'h00);
      chk("irq_set", {7'h00, irq}, 8'h01);
      rd_reg(8'h0F, v);
      chk("wrap_high", v, 8'h00);
      wr_reg(8'h8C, 8'h00);
      @(posedge clk);
      #1;
      chk("irq_mask", {7'h00, irq}, 8'h00);
      rd_reg(8'h0C, v);
      chk("flag_held", v, 8'h01);
      wr_reg(8'h8C, 8'h01);
      wr_reg(8'h0D, 8'h01);
      rd_reg(8'h0C, v);
      chk("flag_clear", {v[0], irq}, 8'h00);
      rd_reg(8'h0E, w);
      repeat (20) @(posedge clk);
      rd_reg(8'h0E, v);
      chk("stopped", v, w);
      @(posedge clk);
      ccp_reset <= 1'b1;
      @(posedge clk);
      ccp_reset <= 1'b0;
      rd_reg(8'h0E, v);
      rd_reg(8'h0F, w);
      chk("ccp_clear", v | w, 8'h00);
      rd_reg(8'h0F, v);
      chk("high_reread", v, w);
      wrap_up;
   end
endmodule // test_timer16
